// file: ida_pkg.sv
/*
 Constants, register map and carrier types for the inertial diagnostics and alarm block.
 Assumes a 16-bit word register access made by the serial link and a sample tick in the core domain.
*/
package ida_pkg;
   localparam logic [6:0] ADR_THR1   = 7'h26;
   localparam logic [6:0] ADR_THR2   = 7'h28;
   localparam logic [6:0] ADR_CNT1   = 7'h2A;
   localparam logic [6:0] ADR_CNT2   = 7'h2C;
   localparam logic [6:0] ADR_ALMCTL = 7'h2E;
   localparam logic [6:0] ADR_MISC   = 7'h34;
   localparam logic [6:0] ADR_DIAG   = 7'h3C;
   localparam logic [15:0] RST_WORD  = 16'h0000;
   localparam logic [15:0] RST_MISC  = 16'h0006;
   localparam int MISC_MEMTEST  = 11;
   localparam int MISC_AUTOTEST = 10;
   localparam int FLG_ALARM     = 8;
   localparam int FLG_FLASH     = 6;
   localparam int FLG_STDIAG    = 5;
   localparam int FLG_OVR       = 4;
   localparam int FLG_LINK      = 3;
   localparam int FLG_UPD       = 2;
   localparam int FLG_SUPHI     = 1;
   localparam int FLG_SUPLO     = 0;
   localparam int FLG_SENS      = 10;
   localparam int THR_DIR       = 15;
   localparam int ALC_FILT      = 4;
   localparam int ALC_EN        = 2;
   localparam int ALC_POL       = 1;
   localparam int ALC_LINE      = 0;
   localparam int ALC_RATE      = 6;
   localparam int ALC_SRC       = 8;
   localparam logic [3:0] SRC_LAST = 4'hB;

   typedef struct packed {
      logic        wr;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } ida_req_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_BASE  = 3'b001,
      S_POS   = 3'b010,
      S_MRUN  = 3'b011,
      S_MCHK  = 3'b100
   } ida_state_t;
endpackage : ida_pkg

// file: ida_diag.sv
/*
 Diagnostics and alarm logic: self-test, memory test, latched flag word, two alarm comparators.
 Assumes the serial framer delivers word requests on link_clk_i and the sensor datapath supplies
 raw and filtered samples with a one-cycle sample_tick_i in the clock_i domain.
*/
`timescale 1ns/1ps
module ida_diag #(
   parameter int SETTLE     = 16,
   parameter int FLASH_AW   = 10,
   parameter logic [15:0] ST_MIN = 16'h0100
) (
   // Core clock and reset
   input  wire logic                  clock_i,
   input  wire logic                  rst_b_i,
   // Link side, on the serial clock
   input  wire logic                  link_clk_i,
   input  wire logic                  link_req_i,
   input  wire ida_pkg::ida_req_t     link_cmd_i,
   output logic                       link_busy_o,
   output logic                       link_rvalid_o,
   output logic [15:0]                link_rdata_o,
   // Sensor samples, index 0 is source code 1
   input  wire logic                  sample_tick_i,
   input  wire logic [10:0][15:0]     src_raw_i,
   input  wire logic [10:0][15:0]     src_filt_i,
   output logic [1:0]                 stim_o,
   // Error conditions
   input  wire logic                  supply_hi_i,
   input  wire logic                  supply_lo_i,
   input  wire logic                  overrange_i,
   input  wire logic                  flash_upd_fail_i,
   // Flash read port, one-cycle latency
   output logic [FLASH_AW-1:0]        flash_addr_o,
   input  wire logic [15:0]           flash_data_i,
   // Alarm indicator lines
   output logic [1:0]                 line_o,
   output logic [1:0]                 line_oe_o
);
   import ida_pkg::*;

   localparam logic [FLASH_AW-1:0] FLASH_END = '1;

   logic rst_s1, rst_n;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   // Link domain: hold request until core acknowledges by toggle
   logic     lrst_s1, lrst_n;
   logic     req_tog_q, lerr_tog_q, ack_s1, ack_s2, ack_s3, ack_tog_q;
   ida_req_t hold_q;
   logic [15:0] rdata_q;
   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lrst_s1 <= 1'b0;
         lrst_n  <= 1'b0;
      end else begin
         lrst_s1 <= 1'b1;
         lrst_n  <= lrst_s1;
      end
   end
   assign link_busy_o = req_tog_q ^ ack_s3;
   always_ff @(posedge link_clk_i or negedge lrst_n) begin
      if (!lrst_n) begin
         req_tog_q     <= 1'b0;
         lerr_tog_q    <= 1'b0;
         hold_q        <= '0;
         ack_s1        <= 1'b0;
         ack_s2        <= 1'b0;
         ack_s3        <= 1'b0;
         link_rvalid_o <= 1'b0;
         link_rdata_o  <= RST_WORD;
      end else begin
         ack_s1        <= ack_tog_q;
         ack_s2        <= ack_s1;
         ack_s3        <= ack_s2;
         link_rvalid_o <= (ack_s2 != ack_s3) && !hold_q.wr;
         if ((ack_s2 != ack_s3) && !hold_q.wr)
            link_rdata_o <= rdata_q;
         // Request while busy is dropped and reported as a link failure
         if (link_req_i && link_busy_o)
            lerr_tog_q <= ~lerr_tog_q;
         else if (link_req_i) begin
            hold_q    <= link_cmd_i;
            req_tog_q <= ~req_tog_q;
         end
      end
   end

   // Core domain
   logic        rq_s1, rq_s2, rq_s3, er_s1, er_s2, er_s3;
   logic [15:0] misc_q, misc_d, actl_q, actl_d, flags_q, flags_d, rdata_d;
   logic [15:0] thr_q [2];
   logic [15:0] cnt_q [2];
   logic [15:0] thr_d [2];
   logic [15:0] cnt_d [2];
   ida_state_t  st_q, st_d;
   logic [7:0]  wait_q, wait_d, wp_q;
   logic [15:0] base_q [6];
   logic [15:0] base_d [6];
   logic [5:0]  sfail_q, sfail_d;
   logic        mfail_q, mfail_d, lerr_q, lerr_d;
   logic [15:0] sum_q, sum_d;
   logic [FLASH_AW-1:0] fa_q, fa_d;
   logic [1:0]  alm_q, alm_d;
   logic        acc, rd_diag;
   logic [16:0] dlt;

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         {rq_s1, rq_s2, rq_s3, er_s1, er_s2, er_s3} <= '0;
      end else begin
         rq_s1 <= req_tog_q;
         rq_s2 <= rq_s1;
         rq_s3 <= rq_s2;
         er_s1 <= lerr_tog_q;
         er_s2 <= er_s1;
         er_s3 <= er_s2;
      end
   end
   assign acc     = rq_s2 != rq_s3;
   assign rd_diag = acc && !hold_q.wr && (hold_q.addr == ADR_DIAG);

   always_comb begin
      misc_d  = misc_q;
      actl_d  = actl_q;
      thr_d   = thr_q;
      cnt_d   = cnt_q;
      rdata_d = rdata_q;
      st_d    = st_q;
      wait_d  = wait_q;
      base_d  = base_q;
      // Test verdicts are reported once, at the next sample tick
      sfail_d = sample_tick_i ? 6'h00 : sfail_q;
      mfail_d = sample_tick_i ? 1'b0 : mfail_q;
      lerr_d  = lerr_q | (er_s2 != er_s3);
      sum_d   = sum_q;
      fa_d    = fa_q;
      dlt     = '0;
      if (acc && hold_q.wr) begin
         unique case (hold_q.addr)
            ADR_MISC:   misc_d   = hold_q.wdata;
            ADR_ALMCTL: actl_d   = hold_q.wdata;
            ADR_THR1:   thr_d[0] = hold_q.wdata;
            ADR_THR2:   thr_d[1] = hold_q.wdata;
            ADR_CNT1:   cnt_d[0] = hold_q.wdata;
            ADR_CNT2:   cnt_d[1] = hold_q.wdata;
            default:    ;
         endcase
      end else if (acc) begin
         unique case (hold_q.addr)
            ADR_MISC:   rdata_d = misc_q;
            ADR_ALMCTL: rdata_d = actl_q;
            ADR_THR1:   rdata_d = thr_q[0];
            ADR_THR2:   rdata_d = thr_q[1];
            ADR_CNT1:   rdata_d = cnt_q[0];
            ADR_CNT2:   rdata_d = cnt_q[1];
            ADR_DIAG:   rdata_d = flags_q;
            default:    rdata_d = RST_WORD;
         endcase
      end
      unique case (st_q)
         S_IDLE: begin
            wait_d = 8'(SETTLE);
            if (misc_q[MISC_AUTOTEST]) st_d = S_BASE;
            else if (misc_q[MISC_MEMTEST]) begin
               st_d  = S_MRUN;
               fa_d  = '0;
               sum_d = '0;
            end
         end
         S_BASE, S_POS: if (sample_tick_i) begin
            if (wait_q != 8'h00) wait_d = wait_q - 8'h01;
            else if (st_q == S_BASE) begin
               for (int i = 0; i < 6; i++) base_d[i] = src_raw_i[i + 1];
               wait_d = 8'(SETTLE);
               st_d   = S_POS;
            end else begin
               // Each gyro and accel must shift by at least ST_MIN
               for (int i = 0; i < 6; i++) begin
                  dlt        = {src_raw_i[i + 1][15], src_raw_i[i + 1]} - {base_q[i][15], base_q[i]};
                  if (dlt[16]) dlt = 17'h00000 - dlt;
                  sfail_d[i] = dlt < {1'b0, ST_MIN};
               end
               misc_d[MISC_AUTOTEST] = 1'b0;
               st_d = S_IDLE;
            end
         end
         S_MRUN: begin
            // Word at fa_q-1 arrives now; last word holds the expected sum
            if (fa_q != '0) sum_d = sum_q + flash_data_i;
            fa_d = fa_q + 1'b1;
            if (fa_q == FLASH_END) st_d = S_MCHK;
         end
         S_MCHK: begin
            mfail_d = sum_q != flash_data_i;
            misc_d[MISC_MEMTEST] = 1'b0;
            st_d = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
      // A refusal in the same cycle as the clearing read must not be lost
      if (rd_diag) lerr_d = (er_s2 != er_s3);
      // Read clears everything, then live conditions land at the sample tick
      flags_d = rd_diag ? RST_WORD : flags_q;
      flags_d[FLG_SUPHI] = rd_diag ? 1'b0 : flags_q[FLG_SUPHI] & supply_hi_i;
      flags_d[FLG_SUPLO] = rd_diag ? 1'b0 : flags_q[FLG_SUPLO] & supply_lo_i;
      if (lerr_q && !rd_diag) flags_d[FLG_LINK] = 1'b1;
      if (sample_tick_i) begin
         // Accel z..x then gyro z..x, same order as sfail_q
         flags_d[15:FLG_SENS]    = flags_d[15:FLG_SENS] | sfail_q;
         flags_d[FLG_ALARM+1:FLG_ALARM] = flags_d[FLG_ALARM+1:FLG_ALARM] | alm_q;
         flags_d[FLG_FLASH]  = flags_d[FLG_FLASH] | mfail_q;
         flags_d[FLG_STDIAG] = flags_d[FLG_STDIAG] | (|sfail_q);
         flags_d[FLG_OVR]    = flags_d[FLG_OVR] | overrange_i;
         flags_d[FLG_UPD]    = flags_d[FLG_UPD] | flash_upd_fail_i;
         flags_d[FLG_SUPHI]  = supply_hi_i;
         flags_d[FLG_SUPLO]  = supply_lo_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         misc_q    <= RST_MISC;
         actl_q    <= RST_WORD;
         thr_q     <= '{default: RST_WORD};
         cnt_q     <= '{default: RST_WORD};
         flags_q   <= RST_WORD;
         rdata_q   <= RST_WORD;
         ack_tog_q <= 1'b0;
         st_q      <= S_IDLE;
         wait_q    <= 8'h00;
         base_q    <= '{default: RST_WORD};
         sfail_q   <= '0;
         mfail_q   <= 1'b0;
         lerr_q    <= 1'b0;
         sum_q     <= RST_WORD;
         fa_q      <= '0;
         wp_q      <= 8'h00;
         alm_q     <= '0;
      end else begin
         misc_q    <= misc_d;
         actl_q    <= actl_d;
         thr_q     <= thr_d;
         cnt_q     <= cnt_d;
         flags_q   <= flags_d;
         rdata_q   <= rdata_d;
         ack_tog_q <= ack_tog_q ^ acc;
         st_q      <= st_d;
         wait_q    <= wait_d;
         base_q    <= base_d;
         sfail_q   <= sfail_d;
         mfail_q   <= mfail_d;
         lerr_q    <= lerr_d;
         sum_q     <= sum_d;
         fa_q      <= fa_d;
         wp_q      <= wp_q + {7'h00, sample_tick_i};
         alm_q     <= sample_tick_i ? alm_d : alm_q;
      end
   end

   // Automatic test owns the stimulus; manual bits only act when idle
   assign stim_o       = (st_q == S_POS) ? 2'b01 :
                         (st_q == S_IDLE) ? misc_q[9:8] : 2'b00;
   assign flash_addr_o = fa_q;

   for (genvar a = 0; a < 2; a++) begin : g_alm
      logic [15:0]        hist [256];
      logic [3:0]         code;
      logic [15:0]        src;
      logic [7:0]         n;
      logic signed [16:0] val, thr;
      always_comb begin
         code = actl_q[ALC_SRC + 4*a +: 4];
         src  = 16'h0000;
         if (code != 4'h0 && code <= SRC_LAST)
            src = actl_q[ALC_FILT] ? src_filt_i[code - 4'h1] : src_raw_i[code - 4'h1];
         n   = (cnt_q[a][7:0] == 8'h00) ? 8'h01 : cnt_q[a][7:0];
         thr = {{3{thr_q[a][13]}}, thr_q[a][13:0]};
         // Interval counts sample ticks, so it scales with the sample period
         val = actl_q[ALC_RATE + a] ? {src[15], src} - {hist[wp_q - n][15], hist[wp_q - n]}
                                    : {src[15], src};
      end
      always_ff @(posedge clock_i) begin
         if (sample_tick_i) hist[wp_q] <= src;
      end
      assign alm_d[a] = (code != 4'h0) && (code <= SRC_LAST) &&
                        (thr_q[a][THR_DIR] ? (val > thr) : (val < thr));
   end

   logic alarm_on;
   assign alarm_on  = |alm_q;
   assign line_oe_o = actl_q[ALC_EN] ? (actl_q[ALC_LINE] ? 2'b10 : 2'b01) : 2'b00;
   assign line_o    = line_oe_o & {2{alarm_on == actl_q[ALC_POL]}};

   a_stbit_clear: assert property (@(posedge clock_i) disable iff (!rst_n)
      (st_q == S_POS && sample_tick_i && wait_q == 8'h00) |=> !misc_q[MISC_AUTOTEST] && st_q == S_IDLE)
      else $error("auto test bit not cleared");
   a_stim_manual: assert property (@(posedge clock_i) disable iff (!rst_n)
      (st_q == S_IDLE) |-> stim_o == misc_q[9:8]) else $error("manual stimulus wrong");
   a_read_clears: assert property (@(posedge clock_i) disable iff (!rst_n)
      (rd_diag && !sample_tick_i && !lerr_q) |=> flags_q == 16'h0000) else $error("flags kept after read");
   a_flag_return: assert property (@(posedge clock_i) disable iff (!rst_n)
      (sample_tick_i && overrange_i) |=> flags_q[FLG_OVR]) else $error("overrange flag lost");
   a_supply_auto: assert property (@(posedge clock_i) disable iff (!rst_n)
      (!supply_hi_i && !supply_lo_i) [*2] |-> flags_q[1:0] == 2'b00) else $error("supply flag stuck");
   a_alarm_flag: assert property (@(posedge clock_i) disable iff (!rst_n)
      (sample_tick_i && alm_q[0]) |=> flags_q[FLG_ALARM]) else $error("alarm flag missing");
   a_mem_done: assert property (@(posedge clock_i) disable iff (!rst_n)
      (st_q == S_MCHK) |=> !misc_q[MISC_MEMTEST] && mfail_q == (sum_q != $past(flash_data_i)))
      else $error("memory test result wrong");
   a_src_off: assert property (@(posedge clock_i) disable iff (!rst_n)
      (sample_tick_i && actl_q[11:8] == 4'h0) |=> !alm_q[0]) else $error("disabled alarm fired");
   a_line_off: assert property (@(posedge clock_i) disable iff (!rst_n)
      !actl_q[ALC_EN] |-> line_oe_o == 2'b00 && line_o == 2'b00) else $error("line driven while off");
   a_stfail_map: assert property (@(posedge clock_i) disable iff (!rst_n)
      (sample_tick_i && sfail_q[5]) |=> flags_q[15] && flags_q[FLG_STDIAG]) else $error("accel z failure not flagged");
   a_stim_base: assert property (@(posedge clock_i) disable iff (!rst_n)
      (st_q == S_BASE) |-> stim_o == 2'b00) else $error("stimulus during baseline");
   a_link_flag: assert property (@(posedge clock_i) disable iff (!rst_n)
      (lerr_q && !rd_diag) |=> flags_q[FLG_LINK]) else $error("link failure flag missing");
endmodule : ida_diag

// file: ida_host.sv
/*
 Host model: serial-link master issuing one 16-bit word request per access, plus a second one while busy when clash is set.
 Assumes a free-running link clock and the link_busy/rvalid handshake of ida_diag.
*/
`timescale 1ns/1ps
module ida_host (
   // Link clock and answers
   input  wire logic           link_clk_i,
   input  wire logic           link_busy_i,
   input  wire logic           link_rvalid_i,
   input  wire logic [15:0]    link_rdata_i,
   // Requests
   output logic                link_req_o,
   output ida_pkg::ida_req_t   link_cmd_o
);
   import ida_pkg::*;
   int timeouts = 0;
   initial begin
      link_req_o = 1'b0;
      link_cmd_o = '0;
   end
   // Clash keeps a second request up while busy, to provoke a refusal
   task automatic access(input logic wr, input logic [6:0] addr, input logic [15:0] wdata,
                         input bit clash, output logic [15:0] rdata);
      int n;
      rdata = 16'hDEAD;
      n = 0;
      @(negedge link_clk_i);
      while (link_busy_i !== 1'b0 && n < 64) begin
         @(negedge link_clk_i);
         n++;
      end
      link_cmd_o = '{wr: wr, addr: addr, wdata: wdata};
      link_req_o = 1'b1;
      @(negedge link_clk_i);
      if (clash) begin
         link_cmd_o = ~link_cmd_o;
         @(negedge link_clk_i);
      end
      link_req_o = 1'b0;
      // Released command lines toggle so stale values cannot be relied on
      link_cmd_o = ~link_cmd_o;
      n = 0;
      while (n < 64) begin
         // Sampled away from the edge that launches the answer
         @(negedge link_clk_i);
         if (link_rvalid_i === 1'b1) rdata = link_rdata_i;
         if (link_busy_i === 1'b0) break;
         n++;
      end
      if (n >= 64) timeouts++;
   endtask : access
endmodule : ida_host

// file: testbench.sv
/*
 Self-checking bench for ida_diag: registers, self-test, memory test, flags, alarms.
 Assumes ida_host as link master and a bench-made sample tick every 8 core cycles.
*/
`timescale 1ns/1ps
module testbench;
   import ida_pkg::*;
   localparam int AW = 4;
   logic clock_i = 1'b0, rst_b_i = 1'b0, link_clk_i = 1'b0, sample_tick_i = 1'b0;
   logic link_req_i, link_busy_o, link_rvalid_o;
   ida_req_t link_cmd_i;
   logic [15:0] link_rdata_o, flash_data_i = 16'h0000, r;
   logic [10:0][15:0] src_raw_i, base, shift;
   logic [1:0] stim_o, line_o, line_oe_o;
   logic supply_hi_i = 1'b0, supply_lo_i = 1'b0, overrange_i = 1'b0, flash_upd_fail_i = 1'b0;
   logic [AW-1:0] flash_addr_o, fa_last = 4'h0;
   logic [15:0] mem [16];
   logic [3:0] tcnt = 4'h0;
   int miscompares = 0, num_checks = 0, cycles = 0, hi;
   logic [6:0] ra [8] = '{ADR_THR1, ADR_THR2, ADR_CNT1, ADR_CNT2, ADR_ALMCTL, ADR_MISC, ADR_DIAG, 7'h00};
   logic [15:0] wv [4] = '{16'hA5C3, 16'h3E0C, 16'h0050, 16'h0008};
   logic [15:0] ac [9] = '{16'h0206, 16'h0216, 16'h0206, 16'h0206, 16'h0204, 16'h0207, 16'h3006, 16'h0202, 16'h0006};
   logic [15:0] at [9] = '{16'h8100, 16'h8100, 16'h0100, 16'h0100, 16'h8100, 16'h8100, 16'h8100, 16'h8100, 16'h8100};
   logic [15:0] av [9] = '{16'h0200, 16'h0200, 16'h0200, 16'hFFF0, 16'h0050, 16'h0200, 16'h0200, 16'h0200, 16'h0200};
   logic [15:0] ae [9] = '{16'h0105, 16'h0004, 16'h0004, 16'h0105, 16'h0005, 16'h010A, 16'h0205, 16'h0100, 16'h0004};
   logic [15:0] cn [3] = '{16'h0000, 16'h0001, 16'h0004};

   always #4 clock_i = ~clock_i;
   initial begin
      #17;
      forever #62.5 link_clk_i = ~link_clk_i;
   end
   always @(negedge clock_i) begin
      tcnt <= tcnt + 4'h1;
      sample_tick_i <= (tcnt[2:0] == 3'h7);
   end
   // Flash answers the previous cycle's address, driven on the falling edge
   always @(negedge clock_i) begin
      fa_last      <= flash_addr_o;
      flash_data_i <= mem[fa_last];
   end
   // Sensors shift with the stimulus direction
   always_comb for (int k = 0; k < 11; k++) src_raw_i[k] = base[k] + (stim_o[0] ? shift[k] : 16'h0000)
                                                         - (stim_o[1] ? shift[k] : 16'h0000);

   ida_diag #(.SETTLE(2), .FLASH_AW(AW)) ida_diag_i (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk_i), .link_req_i(link_req_i),
      .link_cmd_i(link_cmd_i), .link_busy_o(link_busy_o), .link_rvalid_o(link_rvalid_o),
      .link_rdata_o(link_rdata_o), .sample_tick_i(sample_tick_i), .src_raw_i(src_raw_i),
      .src_filt_i('0), .stim_o(stim_o), .supply_hi_i(supply_hi_i), .supply_lo_i(supply_lo_i),
      .overrange_i(overrange_i), .flash_upd_fail_i(flash_upd_fail_i), .flash_addr_o(flash_addr_o),
      .flash_data_i(flash_data_i), .line_o(line_o), .line_oe_o(line_oe_o));
   ida_host ida_host_i (.link_clk_i(link_clk_i), .link_busy_i(link_busy_o), .link_rvalid_i(link_rvalid_o),
      .link_rdata_i(link_rdata_o), .link_req_o(link_req_i), .link_cmd_o(link_cmd_i));

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] x;
      ida_host_i.access(1'b1, a, d, 1'b0, x);
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [15:0] x);
      ida_host_i.access(1'b0, a, 16'h0000, 1'b0, x);
   endtask : rd
   task automatic rdc(input string n, input logic [6:0] a, input logic [15:0] e);
      logic [15:0] x;
      rd(a, x);
      check(n, e, x);
   endtask : rdc
   task automatic ticks(input int n);
      repeat (n * 8) @(negedge clock_i);
   endtask : ticks
   // Poll until the control bit drops, bounded
   task automatic poll(input int b);
      logic [15:0] x;
      int n;
      x = 16'hFFFF;
      n = 0;
      while (x[b] !== 1'b0 && n < 300) begin
         rd(ADR_MISC, x);
         n++;
      end
      check("misc after test", RST_MISC, x);
   endtask : poll
   task automatic give_verdict;
      miscompares += ida_host_i.timeouts;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         give_verdict();
      end
   end

   initial begin
      base = '0;
      shift = '0;
      for (int k = 1; k < 7; k++) shift[k] = 16'h0200;
      shift[6] = 16'h0010;
      for (int k = 1; k < 7; k++) base[k] = 16'h1000;
      mem[15] = 16'h0000;
      for (int k = 0; k < 15; k++) begin
         mem[k] = 16'(k * 16'h1111);
         mem[15] = mem[15] + mem[k];
      end
      repeat (16) @(negedge clock_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge link_clk_i);
      for (int i = 0; i < 8; i++) rdc("reset value", ra[i], (i == 5) ? RST_MISC : RST_WORD);
      for (int i = 0; i < 4; i++) wr(ra[i], wv[i]);
      for (int i = 0; i < 4; i++) rdc("readback", ra[i], wv[i]);
      wr(ADR_DIAG, 16'hFFFF);
      rdc("flag word write", ADR_DIAG, 16'h0000);
      wr(ADR_MISC, 16'h0206);
      check("stim negative", 16'h0002, {14'h0000, stim_o});
      wr(ADR_MISC, 16'h0106);
      check("stim positive", 16'h0001, {14'h0000, stim_o});
      wr(ADR_MISC, 16'h0006);
      check("stim off", 16'h0000, {14'h0000, stim_o});
      wr(ADR_MISC, 16'h0406);
      poll(MISC_AUTOTEST);
      rdc("self-test flags", ADR_DIAG, 16'h8020);
      rdc("flags after read", ADR_DIAG, 16'h0000);
      wr(ADR_MISC, 16'h0806);
      poll(MISC_MEMTEST);
      rdc("memtest pass", ADR_DIAG, 16'h0000);
      mem[15] = mem[15] ^ 16'h0001;
      wr(ADR_MISC, 16'h0806);
      poll(MISC_MEMTEST);
      rdc("memtest fail", ADR_DIAG, 16'h0040);
      overrange_i = 1'b1;
      flash_upd_fail_i = 1'b1;
      ticks(2);
      rdc("error flags", ADR_DIAG, 16'h0014);
      rdc("error flags again", ADR_DIAG, 16'h0014);
      overrange_i = 1'b0;
      flash_upd_fail_i = 1'b0;
      ticks(2);
      rd(ADR_DIAG, r);
      rdc("errors gone", ADR_DIAG, 16'h0000);
      supply_lo_i = 1'b1;
      ticks(2);
      rdc("supply low", ADR_DIAG, 16'h0001);
      supply_lo_i = 1'b0;
      supply_hi_i = 1'b1;
      ticks(2);
      rdc("supply high", ADR_DIAG, 16'h0002);
      ticks(2);
      supply_hi_i = 1'b0;
      ticks(2);
      rdc("supply recovered", ADR_DIAG, 16'h0000);
      ida_host_i.access(1'b0, ADR_MISC, 16'h0000, 1'b1, r);
      check("read beside refusal", RST_MISC, r);
      rdc("link failure", ADR_DIAG, 16'h0008);
      for (int i = 0; i < 9; i++) begin
         wr(ADR_ALMCTL, ac[i]);
         wr(ADR_THR1, at[i]);
         wr(ADR_THR2, at[i]);
         base[1] = av[i];
         base[2] = av[i];
         ticks(2);
         rd(ADR_DIAG, r);
         ticks(2);
         check("indicator", {12'h000, ae[i][3:0]}, {12'h000, line_oe_o, line_o & line_oe_o});
         rdc("alarm flags", ADR_DIAG, {6'h00, ae[i][9:8], 8'h00});
      end
      wr(ADR_ALMCTL, 16'h0246);
      wr(ADR_THR1, 16'h8100);
      for (int i = 0; i < 3; i++) begin
         base[1] = 16'h0000;
         wr(ADR_CNT1, cn[i]);
         ticks(8);
         rd(ADR_DIAG, r);
         @(posedge sample_tick_i);
         @(negedge clock_i);
         base[1] = 16'h0200;
         hi = 0;
         repeat (8) begin
            @(posedge sample_tick_i);
            repeat (4) @(negedge clock_i);
            if (line_o[0] === 1'b1) hi++;
         end
         check("rate interval", (i == 2) ? 16'h0004 : 16'h0001, 16'(hi));
         rdc("rate flag", ADR_DIAG, 16'h0100);
      end
      give_verdict();
   end
endmodule : testbench
